// *** dv/hho_host_model.sv ***
module hho_host_model (
  // clock and command from the bench
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic i_wr,
  input wire logic i_mem,
  // handshake from the device
  input wire logic i_ready_n,
  // host pins
  output logic o_strobe_n,
  output logic o_write,
  output logic o_mem_sel,
  output logic o_busy
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_strobe_n = 1'b1;
    o_write = 1'b0;
    o_mem_sel = 1'b0;
    o_busy = 1'b0;
  end
  // one word per strobe; released lines show the inverse of their last value
  always @(posedge i_clk) begin
    if (i_go && !o_busy) begin
      o_strobe_n <= 1'b0;
      o_write <= i_wr;
      o_mem_sel <= i_mem;
      o_busy <= 1'b1;
    end else if (!o_strobe_n && !i_ready_n) begin
      o_strobe_n <= 1'b1;
      o_write <= ~o_write;
      o_mem_sel <= ~o_mem_sel;
    end else if (o_strobe_n && i_ready_n) begin
      o_busy <= 1'b0;
    end
  end
endmodule

// *** dv/hho_top_assertions.sv ***
module hho_top_assertions #(
  parameter int WDOG_CYCLES = 8
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_int_done,
  input wire logic o_host_ready_handshake_n,
  input wire logic o_io_buffer_enable_n,
  input wire logic o_int_req,
  input wire logic o_int_mem_sel,
  input wire logic o_int_write,
  input wire logic o_zero_wait,
  input wire logic o_transparent
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int WMAX = WDOG_CYCLES + 2;
  logic zw_mode;
  // zero-wait behaviour only applies in buffered mode
  assign zw_mode = o_zero_wait && !o_transparent;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // handshake relations, all in the one clock domain
  a_reset_idle:
    assert property ($rose(i_rst_n) |-> o_host_ready_handshake_n && o_io_buffer_enable_n)
    else $error("handshakes not idle after reset");
  a_io_buffer_enable_n_access: assert property (o_io_buffer_enable_n == !o_int_req) else $error("io_buffer_enable_n");
  a_done_ends:
    assert property (o_int_req && i_int_done |=> !o_int_req && o_io_buffer_enable_n)
    else $error("access not ended by done");
  a_nzw_ready:
    assert property (!zw_mode && o_int_req && i_int_done |=> !o_host_ready_handshake_n)
    else $error("ready not low after done");
  a_nzw_wait:
    assert property (!zw_mode && o_int_req |-> o_host_ready_handshake_n)
    else $error("ready low before data");
  a_zw_low:
    assert property (zw_mode && o_int_req |-> !o_host_ready_handshake_n)
    else $error("ready high during access");
  a_zw_rise:
    assert property (zw_mode && o_int_req && i_int_done |=> o_host_ready_handshake_n)
    else $error("ready not back high");
  a_zw_idle:
    assert property (zw_mode && !o_int_req |-> o_host_ready_handshake_n)
    else $error("ready low while idle");
  a_req_bound: assert property ($rose(o_int_req) |-> ##[1:WMAX] !o_int_req) else $error("hang");
  a_sel_stable:
    assert property (o_int_req && $past(o_int_req) |-> $stable(o_int_mem_sel) && $stable(o_int_write))
    else $error("select moved");
endmodule

bind hho_top hho_top_assertions #(.WDOG_CYCLES(WDOG_CYCLES)) chk_u (.i_clk, .i_rst_n,
  .i_int_done, .o_host_ready_handshake_n, .o_io_buffer_enable_n, .o_int_req,
  .o_int_mem_sel, .o_int_write, .o_zero_wait, .o_transparent);

// *** dv/tb.sv ***
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, trans = 1, zw = 0, done = 0, go = 0, wr = 0, mem = 0;
  logic strobe_n, hwr, hmem, busy, ready_n, io_buffer_enable_n_n, req, isel, iwr, tr_o, zw_o, to_o;
  hho_pkg::hho_state_t st_o;
  localparam int WDOG = 8;
  int n_mismatch = 0, n_compared = 0;
  always #20 clk = ~clk;
  hho_top #(.WDOG_CYCLES(WDOG)) dut_u (.i_clk(clk), .i_rst_n(rst_n), .i_host_strobe_n(strobe_n),
    .i_host_write(hwr), .i_host_mem_reg_sel(hmem), .i_transparent_sel(trans),
    .i_zero_wait_sel(zw), .o_host_ready_handshake_n(ready_n), .o_io_buffer_enable_n(io_buffer_enable_n_n),
    .o_int_req(req), .o_int_mem_sel(isel), .o_int_write(iwr), .i_int_done(done),
    .o_transparent(tr_o), .o_zero_wait(zw_o), .o_timeout(to_o), .o_state(st_o));
  hho_host_model host_u (.i_clk(clk), .i_go(go), .i_wr(wr), .i_mem(mem), .i_ready_n(ready_n),
    .o_strobe_n(strobe_n), .o_write(hwr), .o_mem_sel(hmem), .o_busy(busy));
  task finish_test;
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic a, input logic e);
    n_compared++;
    if (a !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, a, e);
    end
  endtask
  task chk_cnt(input logic [7:0] a, input logic [7:0] e);
    n_compared++;
    if (a !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, a, e);
    end
  endtask
  task chk_st(input hho_pkg::hho_state_t a, input hho_pkg::hho_state_t e);
    n_compared++;
    if (a !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, a, e);
    end
  endtask
  // bounded wait on the access request or on the host being idle
  task wait_for(input logic sel, input logic v);
    for (int k = 0; k < 20; k++) begin
      @(negedge clk);
      if ((sel ? busy : req) === v) return;
    end
    n_mismatch++;
    finish_test();
  endtask
  task do_reset(input logic t, input logic z);
    @(posedge clk);
    rst_n <= 1'b0;
    trans <= t;
    zw <= z;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk(ready_n, 1'b1);
    chk(io_buffer_enable_n_n, 1'b1);
    @(negedge clk);
    chk(tr_o, t);
  endtask
  task xfer(input logic w, input logic m, input logic z);
    @(posedge clk);
    go <= 1'b1;
    wr <= w;
    mem <= m;
    @(posedge clk);
    go <= 1'b0;
    wait_for(1'b0, 1'b1);
    chk(io_buffer_enable_n_n, 1'b0);
    chk(isel, m);
    chk(iwr, w);
    chk(ready_n, ~z);
    repeat (3) @(posedge clk);
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    @(negedge clk);
    chk(io_buffer_enable_n_n, 1'b1);
    chk(ready_n, z);
    chk(req, 1'b0);
    chk_st(st_o, z ? hho_pkg::HHO_IDLE : hho_pkg::HHO_HOLD);
    wait_for(1'b1, 1'b0);
    chk(ready_n, 1'b1);
  endtask
  task t_nonzero_wait;
    // zero-wait strap set but ignored in transparent mode
    do_reset(1'b1, 1'b1);
    xfer(1'b0, 1'b0, 1'b0);
    xfer(1'b1, 1'b1, 1'b0);
    $display("nonzero wait test done");
  endtask
  task t_zero_wait;
    do_reset(1'b0, 1'b1);
    chk(zw_o, 1'b1);
    xfer(1'b0, 1'b1, 1'b1);
    xfer(1'b1, 1'b0, 1'b1);
    $display("zero wait test done");
  endtask
  // an access that never completes is ended by the watchdog
  task t_watchdog;
    int n;
    n = 0;
    @(posedge clk);
    go <= 1'b1;
    wr <= 1'b0;
    mem <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    wait_for(1'b0, 1'b1);
    while (to_o !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    if (n >= 20) begin
      n_mismatch++;
      finish_test();
    end
    chk_cnt(8'(n), 8'(WDOG));
    chk(req, 1'b0);
    chk(io_buffer_enable_n_n, 1'b1);
    chk(ready_n, 1'b1);
    @(negedge clk);
    chk(to_o, 1'b0);
    wait_for(1'b1, 1'b0);
    $display("watchdog test done");
  endtask
  initial begin
    @(posedge clk);
    t_nonzero_wait();
    t_zero_wait();
    t_watchdog();
    finish_test();
  end
endmodule

// *** verilog/hho_pkg.sv ***
package hho_pkg;
  typedef enum logic [1:0] {
    HHO_IDLE,
    HHO_ACCESS,
    HHO_HOLD
  } hho_state_t;
endpackage

// *** verilog/hho_regs.svh ***
`ifndef HHO_REGS_SVH
`define HHO_REGS_SVH
// What this block does
// - on a nonzero-wait read the ready handshake goes low once read data sits on the data bus.
// - on a nonzero-wait write the ready handshake goes low once the data is stored internally.
// - in buffered zero-wait mode the ready handshake idles high, so another cycle may start.
// - in zero-wait mode ready falls during or just after the strobe, as the access begins.
// - in zero-wait mode ready rises when the access ends; the host waits for it.
// - the I/O buffer enable is low for as long as the internal access to registers or RAM runs.

// idle (inactive) levels of the two handshake outputs
`define HHO_READY_IDLE 1'b1
`define HHO_IO_BUFFER_ENABLE_N_IDLE 1'b1
// strap encodings
`define HHO_MODE_TRANSPARENT 1'b1
`define HHO_MODE_BUFFERED 1'b0
`define HHO_SEL_MEMORY 1'b1
// bit positions of the pin bundle passed through the synchroniser
`define HHO_PIN_STROBE 0
`define HHO_PIN_WRITE 1
`define HHO_PIN_MEMREG 2
`define HHO_PIN_MODE 3
`define HHO_PIN_ZWAIT 4
`define HHO_PIN_COUNT 5
// default watchdog length of one internal access, in clock cycles
`define HHO_WDOG_CYCLES 256
`endif

// *** verilog/hho_sync.sv ***
module hho_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] i_async,
  input wire logic [WIDTH-1:0] i_reset_val,
  output logic [WIDTH-1:0] o_sync
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stab;
  } hho_sync_st_t;

  hho_sync_st_t st_q;
  hho_sync_st_t st_d;

  // width must be at least one bit
  if (WIDTH < 1) begin
    $error("hho_sync width must be at least 1");
  end

  // the first stage feeds only the second stage
  always_comb begin
    st_d = st_q;
    st_d.meta = i_async;
    st_d.stab = st_q.meta;
  end

  // both stages keep shifting through reset, so straps are settled at release
  always_ff @(posedge i_clk) begin
    st_q <= st_d;
  end

  // during reset the consumer sees the idle levels, afterwards the second stage
  assign o_sync = i_rst_n ? st_q.stab : i_reset_val;
endmodule

// *** verilog/hho_top.sv ***
`include "hho_regs.svh"

module hho_top #(
  parameter int WDOG_CYCLES = `HHO_WDOG_CYCLES
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // host pins, asynchronous to i_clk
  input wire logic i_host_strobe_n,
  input wire logic i_host_write,
  input wire logic i_host_mem_reg_sel,
  input wire logic i_transparent_sel,
  input wire logic i_zero_wait_sel,
  // host handshake pins
  output logic o_host_ready_handshake_n,
  output logic o_io_buffer_enable_n,
  // internal register and RAM access port
  output logic o_int_req,
  output logic o_int_mem_sel,
  output logic o_int_write,
  input wire logic i_int_done,
  // status
  output logic o_transparent,
  output logic o_zero_wait,
  output logic o_timeout,
  output hho_pkg::hho_state_t o_state
);
  import hho_pkg::*;

  localparam int WDW = $clog2(WDOG_CYCLES + 1);

  typedef struct packed {
    hho_state_t state;
    logic strb_prev;
    logic strap_taken;
    logic transparent;
    logic zero_wait;
    logic ready_n;
    logic io_buffer_enable_n_n;
    logic req;
    logic mem_sel;
    logic write;
    logic timeout;
    logic [WDW-1:0] wd_cnt;
  } hho_st_t;

  hho_st_t st_q;
  hho_st_t st_d;
  logic [`HHO_PIN_COUNT-1:0] pins_raw;
  logic [`HHO_PIN_COUNT-1:0] pins_s;
  logic strb_s;
  logic strb_fall;
  logic start_zw;

  // refuse a watchdog that cannot count
  if (WDOG_CYCLES < 2) begin
    $error("hho_top WDOG_CYCLES must be at least 2");
  end

  // gather the asynchronous pins into one bundle
  always_comb begin
    pins_raw = '0;
    pins_raw[`HHO_PIN_STROBE] = i_host_strobe_n;
    pins_raw[`HHO_PIN_WRITE] = i_host_write;
    pins_raw[`HHO_PIN_MEMREG] = i_host_mem_reg_sel;
    pins_raw[`HHO_PIN_MODE] = i_transparent_sel;
    pins_raw[`HHO_PIN_ZWAIT] = i_zero_wait_sel;
  end

  // two flip-flops before any logic reads a pin
  hho_sync #(
    .WIDTH(`HHO_PIN_COUNT)
  ) u_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_async(pins_raw),
    .i_reset_val({`HHO_PIN_COUNT{1'b1}}),
    .o_sync(pins_s)
  );

  // falling edge of the synchronised strobe starts a transfer
  assign strb_s = pins_s[`HHO_PIN_STROBE];
  assign strb_fall = st_q.strb_prev & ~strb_s;
  assign start_zw = st_q.zero_wait & ~st_q.transparent;

  // next-state logic
  always_comb begin
    st_d = st_q;
    st_d.strb_prev = strb_s;
    st_d.timeout = 1'b0;
    // straps are caught once, on the first cycle after reset release
    if (!st_q.strap_taken) begin
      st_d.strap_taken = 1'b1;
      st_d.transparent = (pins_s[`HHO_PIN_MODE] == `HHO_MODE_TRANSPARENT);
      st_d.zero_wait = pins_s[`HHO_PIN_ZWAIT];
    end
    case (st_q.state)
      HHO_IDLE: begin
        st_d.ready_n = `HHO_READY_IDLE;
        st_d.io_buffer_enable_n_n = `HHO_IO_BUFFER_ENABLE_N_IDLE;
        st_d.wd_cnt = '0;
        if (st_q.strap_taken && strb_fall) begin
          st_d.state = HHO_ACCESS;
          st_d.req = 1'b1;
          st_d.io_buffer_enable_n_n = 1'b0;
          st_d.mem_sel = (pins_s[`HHO_PIN_MEMREG] == `HHO_SEL_MEMORY);
          st_d.write = pins_s[`HHO_PIN_WRITE];
          if (start_zw) begin
            st_d.ready_n = 1'b0;
          end
        end
      end
      HHO_ACCESS: begin
        st_d.wd_cnt = st_q.wd_cnt + WDW'(1);
        // I/O enable stays low while the internal access runs
        st_d.io_buffer_enable_n_n = 1'b0;
        if (i_int_done || st_q.wd_cnt == WDW'(WDOG_CYCLES - 1)) begin
          st_d.req = 1'b0;
          st_d.io_buffer_enable_n_n = `HHO_IO_BUFFER_ENABLE_N_IDLE;
          st_d.timeout = ~i_int_done;
          if (start_zw) begin
            // zero-wait: ready returns high as the access completes
            st_d.ready_n = `HHO_READY_IDLE;
            st_d.state = HHO_IDLE;
          end else begin
            // nonzero-wait: read data valid or write stored, so assert ready
            st_d.ready_n = 1'b0;
            st_d.state = HHO_HOLD;
          end
        end
      end
      HHO_HOLD: begin
        // host keeps strobe low until it sees ready low, then releases it
        if (strb_s) begin
          st_d.ready_n = `HHO_READY_IDLE;
          st_d.state = HHO_IDLE;
        end
      end
      default: begin
        st_d.state = HHO_IDLE;
      end
    endcase
  end

  // state register, handshake outputs idle high after reset
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_q.state <= HHO_IDLE;
      st_q.strb_prev <= 1'b1;
      st_q.strap_taken <= 1'b0;
      st_q.transparent <= `HHO_MODE_BUFFERED;
      st_q.zero_wait <= 1'b0;
      st_q.ready_n <= `HHO_READY_IDLE;
      st_q.io_buffer_enable_n_n <= `HHO_IO_BUFFER_ENABLE_N_IDLE;
      st_q.req <= 1'b0;
      st_q.mem_sel <= 1'b0;
      st_q.write <= 1'b0;
      st_q.timeout <= 1'b0;
      st_q.wd_cnt <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from the state flops; buffer enable serves transparent systems
  assign o_host_ready_handshake_n = st_q.ready_n;
  assign o_io_buffer_enable_n = st_q.io_buffer_enable_n_n;
  assign o_int_req = st_q.req;
  assign o_int_mem_sel = st_q.mem_sel;
  assign o_int_write = st_q.write;
  assign o_transparent = st_q.transparent;
  assign o_zero_wait = st_q.zero_wait;
  assign o_timeout = st_q.timeout;
  assign o_state = st_q.state;
endmodule
